// ===== shared/pmic_power_mode_cfg.svh
// Summary of operation
// - five states only: on, off, sleep, standby, coin cell.
// - no power-up unless input is above undervoltage threshold.
// - configuration bus is locked out in coin cell.
// - interrupt output works only in sleep, standby and on.
// - turn-on enters on and holds host reset high.
// - turn-off with no off-mode select set, or thermal shutdown, forces off; host reset low there.
// - in off only core digital and backup supplies stay enabled.
// - standby follows the decoded low-power request.
// - decoded request is pin level xor polarity invert bit.
// - polarity invert bit is bit 6 of register 0x1b.
// - low-power request matters only in on, and in standby for its release.
// - standby regulator settings start as copies of on settings.
// - entry delay field bits 5:4 of 0x1b, reset 01, 0-3 periods.
// - non-zero entry delay holds off standby response until expiry.
// - request qualification adds three clock cycles of synchronisation.
// - sleep entered on button inactive with off-mode select set; exits on assert.
// - sleep uses off-mode set points, 6-bit for the first two regulators, 7-bit others.
// - off-mode select 0 turns regulator off, 1 keeps it in pfm.
// - in sleep, unmasked faults still assert the interrupt.
// - coin cell rejects turn-on, holds reset low, leaves on input valid.
// - loss of backup power resets every configuration bit to default.
// - button style 0 is active-high level, 1 is mechanical switch.
// - regulators enabled in sleep stay enabled into on.
`ifndef PMIC_POWER_MODE_CFG_SVH
`define PMIC_POWER_MODE_CFG_SVH
`define POWER_CONTROL_ADDR 8'h1b
`define POLARITY_INVERT_BIT 6
`define ENTRY_DELAY_HI 5
`define ENTRY_DELAY_LO 4
`define POWER_CONTROL_RESET 8'h10
`define SYNC_EXTRA_CYCLES 2'h3
`define NUM_REGS 4
`endif

// ===== shared/pmic_power_mode_pkg.sv
package pmic_power_mode_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_COIN,
    ST_SLEEP,
    ST_STANDBY,
    ST_ON
  } power_state_t;

  typedef struct packed {
    logic [6:0] setpoint;
    logic off_mode_select;
  } reg_cfg_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;
endpackage : pmic_power_mode_pkg

// ===== verilog/pmic_power_mode_fsm.sv
`timescale 1ns/1ps
`include "pmic_power_mode_cfg.svh"
module pmic_power_mode_fsm
  import pmic_power_mode_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic vin_above_uv,
  input wire logic backup_power_on_reset,
  input wire logic low_power_request_pin,
  input wire logic power_button_input,
  input wire logic power_button_long_press,
  input wire logic power_button_reset_enable,
  input wire logic thermal_shutdown,
  input wire logic fault_pending,
  input wire cfg_req_t cfg_req,
  input wire reg_cfg_t [`NUM_REGS-1:0] on_cfg,
  input wire reg_cfg_t [`NUM_REGS-1:0] sleep_cfg,
  output logic [7:0] cfg_rdata,
  output logic cfg_ack,
  output logic host_reset_n,
  output logic irq_n,
  output logic core_digital_supply,
  output logic backup_domain_supply,
  output logic [`NUM_REGS-1:0] reg_enable,
  output logic [`NUM_REGS-1:0] reg_pfm,
  output logic [6:0] reg_setpoint [`NUM_REGS],
  output power_state_t state,
  output logic standby_active
);
  power_state_t state_r, state_nxt;
  logic [7:0] power_control_r;
  logic [1:0] lp_sync_r;
  logic [1:0] btn_sync_r;
  logic [`NUM_REGS-1:0] off_sel;
  logic [1:0] delay_cnt_r;
  logic [1:0] delay_cnt_nxt;
  logic [1:0] qual_cnt_r;
  logic [1:0] qual_cnt_nxt;
  logic lp_qualified_r;
  logic lp_qualified_nxt;
  logic [`NUM_REGS-1:0] reg_enable_r;
  logic [6:0] setpoint_r [`NUM_REGS];
  logic [6:0] standby_set_r [`NUM_REGS];
  logic host_reset_n_r;
  logic irq_n_r;
  logic [7:0] rdata_r;

  // combined reset: block reset or backup power lost
  wire full_reset = reset | backup_power_on_reset;
  wire lp_pin_s = lp_sync_r[1];
  wire btn_s = btn_sync_r[1];
  wire polarity_invert = power_control_r[`POLARITY_INVERT_BIT];
  wire button_style = power_control_r[7];
  wire [1:0] entry_delay = power_control_r[`ENTRY_DELAY_HI:`ENTRY_DELAY_LO];
  wire lp_decoded = lp_pin_s ^ polarity_invert;
  wire any_off_mode = |off_sel;
  // button turn-on: level or switch press
  wire btn_on = button_style ? (~btn_s & ~power_button_long_press) : btn_s;
  wire btn_off_cond = button_style ?
    (~btn_s & power_button_long_press & power_button_reset_enable) : ~btn_s;
  wire turn_on = btn_on & vin_above_uv;
  wire cfg_allowed = (state_r != ST_COIN);
  wire cfg_hit = cfg_allowed & (cfg_req.addr == `POWER_CONTROL_ADDR);
  wire cfg_write = cfg_req.wr & cfg_hit;
  wire in_on = (state_r == ST_ON);
  // request only watched in on, or in standby while waiting for release
  wire lp_watch = in_on | (state_r == ST_STANDBY);
  wire lp_ready = lp_qualified_r & (delay_cnt_r == 2'h0);
  // outputs follow the state being entered
  wire nxt_awake = (state_nxt == ST_ON) | (state_nxt == ST_STANDBY) |
    (state_nxt == ST_SLEEP);

  // pin synchronisers, two flops each
  always_ff @(posedge clk)
  begin
    lp_sync_r <= {lp_sync_r[0], low_power_request_pin};
    btn_sync_r <= {btn_sync_r[0], power_button_input};
  end

  // qualification: three extra cycles on a decoded change
  always_comb
  begin
    qual_cnt_nxt = qual_cnt_r;
    lp_qualified_nxt = lp_qualified_r;
    if (!lp_watch)
    begin
      // stale requests from other states are dropped
      qual_cnt_nxt = 2'h0;
      lp_qualified_nxt = 1'b0;
    end
    else if (lp_decoded != lp_qualified_r)
    begin
      if (qual_cnt_r == `SYNC_EXTRA_CYCLES - 2'h1)
      begin
        lp_qualified_nxt = lp_decoded;
        qual_cnt_nxt = 2'h0;
      end
      else
      begin
        qual_cnt_nxt = qual_cnt_r + 2'h1;
      end
    end
    else
    begin
      qual_cnt_nxt = 2'h0;
    end
  end

  // entry delay counter
  always_comb
  begin
    delay_cnt_nxt = delay_cnt_r;
    if (!(lp_qualified_r & in_on))
    begin
      delay_cnt_nxt = entry_delay;
    end
    else if (delay_cnt_r != 2'h0)
    begin
      delay_cnt_nxt = delay_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (full_reset)
    begin
      qual_cnt_r <= 2'h0;
      lp_qualified_r <= 1'b0;
      delay_cnt_r <= 2'h1;
    end
    else
    begin
      qual_cnt_r <= qual_cnt_nxt;
      lp_qualified_r <= lp_qualified_nxt;
      delay_cnt_r <= delay_cnt_nxt;
    end
  end

  // mode transitions
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_COIN:
      begin
        if (vin_above_uv)
        begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF:
      begin
        if (!vin_above_uv)
        begin
          state_nxt = ST_COIN;
        end
        else if (turn_on && !thermal_shutdown)
        begin
          state_nxt = ST_ON;
        end
      end
      ST_SLEEP:
      begin
        if (!vin_above_uv)
        begin
          state_nxt = ST_COIN;
        end
        else if (thermal_shutdown || (button_style && btn_off_cond))
        begin
          // long press with reset enable also ends sleep
          state_nxt = ST_OFF;
        end
        else if (turn_on)
        begin
          state_nxt = ST_ON;
        end
      end
      ST_STANDBY, ST_ON:
      begin
        if (!vin_above_uv)
        begin
          state_nxt = ST_COIN;
        end
        else if (thermal_shutdown)
        begin
          state_nxt = ST_OFF;
        end
        else if (btn_off_cond)
        begin
          state_nxt = any_off_mode ? ST_SLEEP : ST_OFF;
        end
        else if (in_on && lp_ready)
        begin
          state_nxt = ST_STANDBY;
        end
        else if (state_r == ST_STANDBY && !lp_qualified_r)
        begin
          state_nxt = ST_ON;
        end
      end
      default:
      begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (full_reset)
    begin
      state_r <= ST_COIN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // power control register
  always_ff @(posedge clk)
  begin
    if (full_reset)
    begin
      power_control_r <= `POWER_CONTROL_RESET;
    end
    else if (cfg_write)
    begin
      power_control_r <= cfg_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (full_reset)
    begin
      rdata_r <= 8'h00;
      cfg_ack <= 1'b0;
    end
    else
    begin
      cfg_ack <= cfg_hit;
      rdata_r <= cfg_hit ? power_control_r : 8'h00;
    end
  end

  // per-regulator enable and set point
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REGS; gi = gi + 1)
    begin : g_reg
      wire [6:0] width_mask = (gi < 2) ? 7'h3f : 7'h7f;
      assign off_sel[gi] = sleep_cfg[gi].off_mode_select;
      always_ff @(posedge clk)
      begin
        if (full_reset)
        begin
          reg_enable_r[gi] <= 1'b0;
          setpoint_r[gi] <= 7'h00;
          standby_set_r[gi] <= 7'h00;
        end
        else
        begin
          if (state_r == ST_OFF && state_nxt == ST_ON)
          begin
            standby_set_r[gi] <= on_cfg[gi].setpoint;
          end
          case (state_nxt)
            ST_OFF, ST_COIN:
            begin
              reg_enable_r[gi] <= 1'b0;
            end
            ST_SLEEP:
            begin
              reg_enable_r[gi] <= reg_enable_r[gi] & sleep_cfg[gi].off_mode_select;
              setpoint_r[gi] <= sleep_cfg[gi].setpoint & width_mask;
            end
            ST_STANDBY:
            begin
              setpoint_r[gi] <= standby_set_r[gi];
            end
            default:
            begin
              reg_enable_r[gi] <= 1'b1;
              setpoint_r[gi] <= on_cfg[gi].setpoint;
            end
          endcase
        end
      end
    end
  endgenerate

  // host reset and interrupt
  always_ff @(posedge clk)
  begin
    if (full_reset)
    begin
      host_reset_n_r <= 1'b0;
      irq_n_r <= 1'b1;
    end
    else
    begin
      host_reset_n_r <= nxt_awake;
      irq_n_r <= ~(fault_pending & nxt_awake);
    end
  end

  assign host_reset_n = host_reset_n_r;
  assign irq_n = irq_n_r;
  assign core_digital_supply = 1'b1;
  assign backup_domain_supply = 1'b1;
  assign reg_enable = reg_enable_r;
  assign reg_pfm = reg_enable_r & off_sel & {`NUM_REGS{state_r == ST_SLEEP}};
  assign reg_setpoint = setpoint_r;
  assign cfg_rdata = rdata_r;
  assign state = state_r;
  assign standby_active = (state_r == ST_STANDBY);
endmodule : pmic_power_mode_fsm

// ===== sim/host_lp_model.sv
`timescale 1ns/1ps
module host_lp_model
(
  input wire logic clk,
  input wire logic want,
  input wire logic invert,
  output logic pin
);
  // request level goes out through the chosen polarity
  initial pin = 1'b0;
  always @(posedge clk) pin <= want ^ invert;
endmodule : host_lp_model

// ===== sim/pmic_power_mode_sva.sv
`timescale 1ns/1ps
`include "pmic_power_mode_cfg.svh"
module pmic_power_mode_sva
  import pmic_power_mode_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic backup_power_on_reset,
  input wire logic vin_above_uv,
  input wire logic fault_pending,
  input wire cfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic host_reset_n,
  input wire logic irq_n,
  input wire logic core_digital_supply,
  input wire logic backup_domain_supply,
  input wire logic [`NUM_REGS-1:0] reg_enable,
  input wire power_state_t state,
  input wire logic standby_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || backup_power_on_reset);
  a_five_states: assert property (
    state inside {ST_OFF, ST_COIN, ST_SLEEP, ST_STANDBY, ST_ON}) else $error("illegal state");
  a_coin_needs_vin: assert property (state == ST_COIN && !vin_above_uv |=> state == ST_COIN)
    else $error("left coin cell without input");
  a_coin_exit_off: assert property (
    $past(state) == ST_COIN |-> state inside {ST_COIN, ST_OFF})
    else $error("coin cell left to wrong state");
  a_coin_no_cfg: assert property (state == ST_COIN && cfg_req.wr |=> !cfg_ack)
    else $error("config answered in coin cell");
  a_irq_quiet_off: assert property (state inside {ST_OFF, ST_COIN} [*2] |-> irq_n)
    else $error("interrupt in off or coin cell");
  a_on_reset_high: assert property (state == ST_ON [*2] |-> host_reset_n)
    else $error("host reset low in on");
  a_off_reset_low: assert property (
    state == ST_OFF [*2] |-> !host_reset_n && reg_enable == '0
    && core_digital_supply && backup_domain_supply) else $error("off outputs wrong");
  a_standby_from_on: assert property ($rose(standby_active) |-> $past(state) == ST_ON
    && state == ST_STANDBY) else $error("standby not entered from on");
  a_sleep_irq: assert property (state == ST_SLEEP && fault_pending |=> !irq_n)
    else $error("fault not reported in sleep");
endmodule : pmic_power_mode_sva
bind pmic_power_mode_fsm pmic_power_mode_sva SVA (.clk, .reset, .backup_power_on_reset,
  .vin_above_uv, .fault_pending, .cfg_req, .cfg_ack, .host_reset_n, .irq_n,
  .core_digital_supply, .backup_domain_supply, .reg_enable, .state, .standby_active);

// ===== sim/pmic_power_mode_fsm_bench.sv
`timescale 1ns/1ps
`include "pmic_power_mode_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t value differs", $time); end end
module pmic_power_mode_fsm_bench;
  import pmic_power_mode_pkg::*;
  logic clk, reset, vin, bpor, btn, lp, therm, fault, want, inv, ack, rst_n, irq_n, core, bkp, sb;
  logic [7:0] rdata;
  logic [7:0] cur;
  logic [`NUM_REGS-1:0] en;
  logic [`NUM_REGS-1:0] pfm;
  logic [6:0] sp [`NUM_REGS];
  cfg_req_t req;
  reg_cfg_t [`NUM_REGS-1:0] rcfg;
  power_state_t st;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  int base;
  pmic_power_mode_fsm DUT (.clk(clk), .reset(reset), .vin_above_uv(vin),
    .backup_power_on_reset(bpor), .low_power_request_pin(lp), .power_button_input(btn),
    .power_button_long_press(1'b0), .power_button_reset_enable(1'b0),
    .thermal_shutdown(therm), .fault_pending(fault), .cfg_req(req), .on_cfg(rcfg),
    .sleep_cfg(rcfg), .cfg_rdata(rdata), .cfg_ack(ack), .host_reset_n(rst_n), .irq_n(irq_n),
    .core_digital_supply(core), .backup_domain_supply(bkp), .reg_enable(en), .reg_pfm(pfm),
    .reg_setpoint(sp), .state(st), .standby_active(sb));
  host_lp_model HOST (.clk(clk), .want(want), .invert(inv), .pin(lp));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task wait_st(input power_state_t s);
    n = 0;
    while (st !== s && n < 60)
    begin
      step(1);
      n++;
    end
    `CHK(st, s)
  endtask : wait_st
  task access(input logic [7:0] a, input logic [7:0] d, input logic k, input logic [7:0] r);
    req = {1'b1, a, d};
    step(1);
    `CHK(ack, k)
    `CHK(rdata, r)
    req = '0;
    step(1);
  endtask : access
  task t_coin();
    `CHK(st, ST_COIN)
    `CHK(rst_n, 1'b0)
    access(8'h1b, 8'h30, 1'b0, 8'h00);
    vin = 1'b1;
    wait_st(ST_OFF);
    step(2);
    `CHK({rst_n, en, core, bkp}, {1'b0, 4'h0, 2'b11})
    access(8'h1b, 8'h10, 1'b1, 8'h10);
    access(8'h6a, 8'hff, 1'b0, 8'h00);
    want = 1'b1;
    step(12);
    `CHK(st, ST_OFF)
    want = 1'b0;
    cur = 8'h10;
  endtask : t_coin
  task t_delay();
    btn = 1'b1;
    wait_st(ST_ON);
    step(1);
    `CHK(rst_n, 1'b1)
    for (int d = 0; d < 4; d++)
    begin
      access(8'h1b, {2'b00, d[1:0], 4'h0}, 1'b1, cur);
      cur = {2'b00, d[1:0], 4'h0};
      want = 1'b1;
      wait_st(ST_STANDBY);
      if (d == 0)
        base = n;
      `CHK(n - base, d)
      `CHK(n >= 3, 1'b1)
      want = 1'b0;
      wait_st(ST_ON);
    end
  endtask : t_delay
  task t_invert();
    inv = 1'b1;
    access(8'h1b, 8'h40, 1'b1, cur);
    step(12);
    `CHK(st, ST_ON)
    want = 1'b1;
    wait_st(ST_STANDBY);
    `CHK(lp, 1'b0)
    want = 1'b0;
    wait_st(ST_ON);
  endtask : t_invert
  task t_sleep();
    rcfg = {`NUM_REGS{8'h81}};
    btn = 1'b0;
    wait_st(ST_SLEEP);
    want = 1'b1;
    fault = 1'b1;
    step(12);
    `CHK({st, irq_n}, {ST_SLEEP, 1'b0})
    `CHK({en, pfm}, 8'hff)
    `CHK(sp[0], 7'h00)
    `CHK(sp[3], 7'h40)
    want = 1'b0;
    fault = 1'b0;
    btn = 1'b1;
    wait_st(ST_ON);
    `CHK(en, 4'hf)
  endtask : t_sleep
  task t_off();
    rcfg = '0;
    btn = 1'b0;
    wait_st(ST_OFF);
    btn = 1'b1;
    wait_st(ST_ON);
    therm = 1'b1;
    wait_st(ST_OFF);
    therm = 1'b0;
    bpor = 1'b1;
    step(1);
    bpor = 1'b0;
    wait_st(ST_ON);
    access(8'h1b, 8'h10, 1'b1, 8'h10);
  endtask : t_off
  initial
  begin
    {vin, bpor, btn, therm, fault, want, inv} = '0;
    req = '0;
    rcfg = '0;
    reset = 1'b1;
    step(8);
    reset = 1'b0;
    t_coin();
    t_delay();
    t_invert();
    t_sleep();
    t_off();
    tally_and_finish();
  end
endmodule : pmic_power_mode_fsm_bench
